// File: rtl/spc_top.sv
// Segment protection checker: load-time descriptor checks, hidden caches,
// reference-time limit and type checks, exception reporting.
// Assumes the partner fetches descriptors on request and holds reference
// inputs stable for the cycle in which it samples ref_go_o.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module spc_top (
  input logic clk_i,
  input logic rst_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input logic wb_we_i,
  input logic [3:0] wb_sel_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq_o,
  input logic ld_req_i,
  input spc_pkg::spc_tgt_t ld_tgt_i,
  input logic [spc_pkg::SEL_W-1:0] ld_sel_i,
  output logic ld_busy_o,
  output logic ld_done_o,
  output logic ld_fault_o,
  output logic desc_rd_o,
  output logic [spc_pkg::BASE_W-1:0] desc_addr_o,
  input logic desc_ack_i,
  input logic [spc_pkg::ACC_W-1:0] desc_acc_i,
  input logic [spc_pkg::LIM_W-1:0] desc_lim_i,
  input logic [spc_pkg::BASE_W-1:0] desc_base_i,
  input logic ref_vld_i,
  input logic [1:0] ref_seg_i,
  input logic [spc_pkg::LIM_W-1:0] ref_off_i,
  input logic ref_wr_i,
  input logic ref_exec_i,
  output logic ref_go_o,
  output logic ref_fault_o,
  output logic [spc_pkg::BASE_W-1:0] ref_base_o,
  input logic io_req_i,
  output logic io_ok_o,
  output logic [1:0] cpl_o,
  output logic exc_o,
  output spc_pkg::spc_cause_t exc_cause_o,
  output logic [spc_pkg::SEL_W-1:0] exc_code_o
);
  import spc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_CHECK = 2'b11
  } spc_ld_st_t;

  // Hidden caches; slot LT_SLOT is the local table register
  logic [SEL_W-1:0] sel_q [NSEG];
  logic [LIM_W-1:0] lim_q [NSEG];
  logic [BASE_W-1:0] base_q [NSEG];
  logic vld_q [NSEG];
  logic [ACC_W-1:0] acc_q [4];

  spc_ld_st_t st_q;
  spc_tgt_t tgt_q;
  logic [SEL_W-1:0] lsel_q;
  spc_cause_t pend_q;
  logic null_q;
  logic [ACC_W-1:0] dacc_q;
  logic [LIM_W-1:0] dlim_q;
  logic [BASE_W-1:0] dbase_q;
  logic [BASE_W-1:0] daddr_q;
  logic [1:0] cpl_q;
  logic done_q;
  logic ldf_q;
  logic exc_q;
  spc_cause_t cause_q;
  logic [SEL_W-1:0] code_q;
  logic [EVT_W-1:0] evt_q;

  logic [BASE_W-1:0] gt_base;
  logic [LIM_W-1:0] gt_lim;
  logic [1:0] io_level;

  logic [IDX_W-1:0] req_idx;
  logic req_ti;
  logic req_null;
  logic [LIM_W-1:0] tbl_lim;
  logic [BASE_W-1:0] tbl_base;
  spc_cause_t early_cause;
  spc_cause_t chk_cause;
  spc_cause_t fin_cause;
  logic commit;
  logic rf_fault;
  spc_cause_t rf_cause;
  logic ref_bad;
  logic io_bad;
  logic [1:0] eff_lvl;

  assign req_idx = ld_sel_i[SEL_W-1:SEL_IDX_LO];
  assign req_ti = ld_sel_i[SEL_TI];
  assign req_null = (req_idx == '0) && !req_ti;
  // Only the global table or this task's own local table are ever consulted
  assign tbl_lim = req_ti ? lim_q[LT_SLOT] : gt_lim;
  assign tbl_base = req_ti ? base_q[LT_SLOT] : gt_base;

  // Checks that need no descriptor fetch
  always_comb begin
    early_cause = CAUSE_NONE;
    if (req_null) begin
      if (ld_tgt_i == TGT_CS || ld_tgt_i == TGT_SS) begin
        early_cause = CAUSE_LD_NULL;
      end
    end else if (ld_tgt_i == TGT_LT && req_ti) begin
      early_cause = CAUSE_LD_TYPE;
    end else if (req_ti && !vld_q[LT_SLOT]) begin
      early_cause = CAUSE_LD_LIMIT;
    end else if ({req_idx, 3'h7} > tbl_lim) begin
      early_cause = CAUSE_LD_LIMIT;
    end
  end

  // Outer of current level and requester level must not be more trusted
  assign eff_lvl = (lsel_q[1:0] > cpl_q) ? lsel_q[1:0] : cpl_q;

  // Descriptor checks; order: empty, kind, privilege, presence
  always_comb begin
    chk_cause = CAUSE_NONE;
    if (dacc_q == '0) begin
      chk_cause = CAUSE_LD_EMPTY;
    end else if (tgt_q == TGT_LT) begin
      if (dacc_q[ACC_S] || dacc_q[3:0] != SYS_TYPE_LT) begin
        chk_cause = CAUSE_LD_TYPE;
      end else if (!dacc_q[ACC_P]) begin
        chk_cause = CAUSE_LD_ABSENT;
      end
    end else if (!dacc_q[ACC_S]) begin
      chk_cause = CAUSE_LD_TYPE;
    end else begin
      unique case (tgt_q)
        TGT_CS: begin
          if (!is_code(dacc_q)) begin
            chk_cause = CAUSE_LD_TYPE;
          end else if (is_conform(dacc_q) ? (acc_dpl(dacc_q) > cpl_q)
                                          : (acc_dpl(dacc_q) != cpl_q)) begin
            chk_cause = CAUSE_LD_PRIV;
          end
        end
        TGT_SS: begin
          if (!is_writable(dacc_q)) begin
            chk_cause = CAUSE_LD_TYPE;
          end else if (acc_dpl(dacc_q) != cpl_q || lsel_q[1:0] != cpl_q) begin
            chk_cause = CAUSE_LD_PRIV;
          end
        end
        default: begin
          if (!is_readable(dacc_q)) begin
            chk_cause = CAUSE_LD_TYPE;
          end else if (!is_conform(dacc_q) && acc_dpl(dacc_q) < eff_lvl) begin
            chk_cause = CAUSE_LD_PRIV;
          end
        end
      endcase
      if (chk_cause == CAUSE_NONE && !dacc_q[ACC_P]) begin
        chk_cause = CAUSE_LD_ABSENT;
      end
    end
  end

  assign fin_cause = (pend_q != CAUSE_NONE) ? pend_q :
                     null_q ? CAUSE_NONE : chk_cause;

  // Reference path is purely combinational alongside address formation
  spc_ref_check u_ref (
    .acc_i(acc_q[ref_seg_i]),
    .lim_i(lim_q[ref_seg_i]),
    .usable_i(vld_q[ref_seg_i]),
    .off_i(ref_off_i),
    .wr_i(ref_wr_i),
    .exec_i(ref_exec_i),
    .fault_o(rf_fault),
    .cause_o(rf_cause)
  );

  assign ref_bad = ref_vld_i & rf_fault;
  assign ref_fault_o = ref_bad;
  assign ref_go_o = ref_vld_i & ~rf_fault;
  assign ref_base_o = base_q[ref_seg_i];

  assign io_bad = io_req_i && (cpl_q > io_level);
  assign io_ok_o = io_req_i && !(cpl_q > io_level);

  // A pending load result waits while a reference or I/O fault holds the slot
  assign commit = (st_q == ST_CHECK) && !ref_bad && !io_bad;
  assign ld_busy_o = (st_q != ST_IDLE);
  assign desc_rd_o = (st_q == ST_FETCH);
  assign desc_addr_o = daddr_q;
  assign ld_done_o = done_q;
  assign ld_fault_o = ldf_q;
  assign cpl_o = cpl_q;
  assign exc_o = exc_q;
  assign exc_cause_o = cause_q;
  assign exc_code_o = code_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (ld_req_i) begin
            st_q <= (early_cause != CAUSE_NONE || req_null) ? ST_CHECK : ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (desc_ack_i) begin
            st_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (commit) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_q <= TGT_ES;
      lsel_q <= '0;
      pend_q <= CAUSE_NONE;
      null_q <= 1'b0;
      daddr_q <= '0;
      dacc_q <= '0;
      dlim_q <= '0;
      dbase_q <= '0;
    end else if (st_q == ST_IDLE && ld_req_i) begin
      tgt_q <= ld_tgt_i;
      lsel_q <= ld_sel_i;
      pend_q <= early_cause;
      null_q <= req_null;
      daddr_q <= tbl_base + {8'h00, req_idx, 3'h0};
    end else if (st_q == ST_FETCH && desc_ack_i) begin
      dacc_q <= desc_acc_i;
      dlim_q <= desc_lim_i;
      dbase_q <= desc_base_i;
    end
  end

  // Hidden parts change only on a successful load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NSEG; i++) begin
        sel_q[i] <= '0;
        lim_q[i] <= '0;
        base_q[i] <= '0;
        vld_q[i] <= 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
        acc_q[i] <= '0;
      end
    end else if (commit && fin_cause == CAUSE_NONE) begin
      for (int i = 0; i < NSEG; i++) begin
        if (tgt_q == spc_tgt_t'(i)) begin
          sel_q[i] <= lsel_q;
          lim_q[i] <= null_q ? '0 : dlim_q;
          base_q[i] <= null_q ? '0 : dbase_q;
          vld_q[i] <= !null_q;
        end
      end
      for (int i = 0; i < 4; i++) begin
        if (tgt_q == spc_tgt_t'(i)) begin
          acc_q[i] <= null_q ? '0 : dacc_q;
        end
      end
    end
  end

  // Current level follows the code segment, except for conforming code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpl_q <= 2'h0;
    end else if (commit && fin_cause == CAUSE_NONE && tgt_q == TGT_CS
                 && !is_conform(dacc_q)) begin
      cpl_q <= acc_dpl(dacc_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      ldf_q <= 1'b0;
    end else begin
      done_q <= commit;
      ldf_q <= commit && (fin_cause != CAUSE_NONE);
    end
  end

  // Reference faults take the slot first: they belong to the current access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_q <= 1'b0;
      cause_q <= CAUSE_NONE;
      code_q <= '0;
      evt_q <= '0;
    end else begin
      exc_q <= 1'b0;
      evt_q <= '0;
      if (ref_bad) begin
        exc_q <= 1'b1;
        cause_q <= rf_cause;
        code_q <= sel_q[ref_seg_i] & 16'hFFFC;
        evt_q[EVT_REF_FAULT] <= 1'b1;
      end else if (io_bad) begin
        exc_q <= 1'b1;
        cause_q <= CAUSE_IO_PRIV;
        code_q <= 16'h0000;
        evt_q[EVT_IO_FAULT] <= 1'b1;
      end else if (commit && fin_cause != CAUSE_NONE) begin
        exc_q <= 1'b1;
        cause_q <= fin_cause;
        code_q <= lsel_q & 16'hFFFC;
        evt_q[EVT_LD_FAULT] <= 1'b1;
      end else if (commit) begin
        evt_q[EVT_LD_DONE] <= 1'b1;
      end
    end
  end

  spc_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .evt_i(evt_q),
    .lt_sel_i(sel_q[LT_SLOT]),
    .lt_base_i(base_q[LT_SLOT]),
    .lt_lim_i(lim_q[LT_SLOT]),
    .fault_info_i({code_q, 10'h000, cpl_q, cause_q}),
    .gt_base_o(gt_base),
    .gt_lim_o(gt_lim),
    .io_level_o(io_level),
    .irq_o(irq_o)
  );

endmodule : spc_top

// File: rtl/spc_pkg.sv
// Constants, types and descriptor helpers for the segment protection checker.
// Assumes one processor clock; shared by the checker core and its submodules.
package spc_pkg;

  localparam int unsigned SEL_W = 16;
  localparam int unsigned IDX_W = 13;
  localparam int unsigned LIM_W = 16;
  localparam int unsigned BASE_W = 24;
  localparam int unsigned ACC_W = 8;
  localparam int unsigned NSEG = 5;
  localparam int unsigned LT_SLOT = 4;

  // Selector layout
  localparam int unsigned SEL_TI = 2;
  localparam int unsigned SEL_IDX_LO = 3;

  // Access byte layout
  localparam int unsigned ACC_P = 7;
  localparam int unsigned ACC_DPL_LO = 5;
  localparam int unsigned ACC_S = 4;
  localparam int unsigned ACC_EXE = 3;
  localparam int unsigned ACC_EC = 2;
  localparam int unsigned ACC_WR = 1;
  localparam logic [3:0] SYS_TYPE_LT = 4'h2;

  // Register map (byte addresses)
  localparam logic [7:0] REG_GT_BASE = 8'h00;
  localparam logic [7:0] REG_GT_LIMIT = 8'h04;
  localparam logic [7:0] REG_LT_SEL = 8'h08;
  localparam logic [7:0] REG_LT_BASE = 8'h0C;
  localparam logic [7:0] REG_LT_LIMIT = 8'h10;
  localparam logic [7:0] REG_IO_LEVEL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_MASK = 8'h1C;
  localparam logic [7:0] REG_FAULT = 8'h20;

  localparam logic [23:0] RST_GT_BASE = 24'h000000;
  localparam logic [15:0] RST_GT_LIMIT = 16'hFFFF;
  localparam logic [1:0] RST_IO_LEVEL = 2'h0;

  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_LD_FAULT = 0;
  localparam int unsigned EVT_REF_FAULT = 1;
  localparam int unsigned EVT_IO_FAULT = 2;
  localparam int unsigned EVT_LD_DONE = 3;
  localparam logic [3:0] RST_MASK = 4'h0;

  typedef enum logic [2:0] {
    TGT_ES = 3'h0, TGT_CS = 3'h1, TGT_SS = 3'h2, TGT_DS = 3'h3, TGT_LT = 3'h4
  } spc_tgt_t;

  // Bit 3 set marks a fault found at reference time or on an I/O request
  typedef enum logic [3:0] {
    CAUSE_NONE = 4'h0, CAUSE_LD_LIMIT = 4'h1, CAUSE_LD_EMPTY = 4'h2,
    CAUSE_LD_TYPE = 4'h3, CAUSE_LD_PRIV = 4'h4, CAUSE_LD_ABSENT = 4'h5,
    CAUSE_LD_NULL = 4'h6, CAUSE_REF_LIMIT = 4'h8, CAUSE_REF_TYPE = 4'h9,
    CAUSE_REF_NULL = 4'hA, CAUSE_IO_PRIV = 4'hB
  } spc_cause_t;

  function automatic logic [1:0] acc_dpl(input logic [7:0] acc);
    acc_dpl = acc[ACC_DPL_LO +: 2];
  endfunction : acc_dpl

  function automatic logic is_code(input logic [7:0] acc);
    is_code = acc[ACC_S] & acc[ACC_EXE];
  endfunction : is_code

  function automatic logic is_writable(input logic [7:0] acc);
    is_writable = acc[ACC_S] & ~acc[ACC_EXE] & acc[ACC_WR];
  endfunction : is_writable

  function automatic logic is_readable(input logic [7:0] acc);
    is_readable = acc[ACC_S] & (~acc[ACC_EXE] | acc[ACC_WR]);
  endfunction : is_readable

  function automatic logic is_expdn(input logic [7:0] acc);
    is_expdn = ~acc[ACC_EXE] & acc[ACC_EC];
  endfunction : is_expdn

  function automatic logic is_conform(input logic [7:0] acc);
    is_conform = acc[ACC_EXE] & acc[ACC_EC];
  endfunction : is_conform

endpackage : spc_pkg

// File: rtl/spc_ref_check.sv
// Combinational limit and type check for one memory reference.
// Assumes the cached descriptor of the addressed segment register is stable.
`timescale 1ns/1ps
module spc_ref_check (
  input logic [spc_pkg::ACC_W-1:0] acc_i,
  input logic [spc_pkg::LIM_W-1:0] lim_i,
  input logic usable_i,
  input logic [spc_pkg::LIM_W-1:0] off_i,
  input logic wr_i,
  input logic exec_i,
  output logic fault_o,
  output spc_pkg::spc_cause_t cause_o
);
  import spc_pkg::*;

  logic in_lim;
  logic type_ok;

  // Expand-down segments own the offsets above the limit
  assign in_lim = is_expdn(acc_i) ? (off_i > lim_i) : (off_i <= lim_i);
  assign type_ok = wr_i ? is_writable(acc_i) :
                   exec_i ? is_code(acc_i) : is_readable(acc_i);

  always_comb begin
    cause_o = CAUSE_NONE;
    if (!usable_i) begin
      cause_o = CAUSE_REF_NULL;
    end else if (!in_lim) begin
      cause_o = CAUSE_REF_LIMIT;
    end else if (!type_ok) begin
      cause_o = CAUSE_REF_TYPE;
    end
  end

  assign fault_o = (cause_o != CAUSE_NONE);

endmodule : spc_ref_check

// File: rtl/spc_wb_regs.sv
// Wishbone classic register slave, sticky event status and interrupt.
// Assumes a single-cycle classic master; answers one cycle after the strobe.
`timescale 1ns/1ps
module spc_wb_regs (
  input logic clk_i,
  input logic rst_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input logic wb_we_i,
  input logic [3:0] wb_sel_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  output logic wb_ack_o,
  input logic [spc_pkg::EVT_W-1:0] evt_i,
  input logic [spc_pkg::SEL_W-1:0] lt_sel_i,
  input logic [spc_pkg::BASE_W-1:0] lt_base_i,
  input logic [spc_pkg::LIM_W-1:0] lt_lim_i,
  input logic [31:0] fault_info_i,
  output logic [spc_pkg::BASE_W-1:0] gt_base_o,
  output logic [spc_pkg::LIM_W-1:0] gt_lim_o,
  output logic [1:0] io_level_o,
  output logic irq_o
);
  import spc_pkg::*;

  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic ack_q;
  logic acc_go;
  logic wr_go;
  logic rd_status;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = sel[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction : lane_merge

  assign acc_go = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_go = acc_go & wb_we_i;
  assign rd_status = acc_go & ~wb_we_i & (wb_adr_i == REG_STATUS);
  assign wb_ack_o = ack_q;
  assign irq_o = |(status_q & mask_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc_go;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gt_base_o <= RST_GT_BASE;
      gt_lim_o <= RST_GT_LIMIT;
      io_level_o <= RST_IO_LEVEL;
      mask_q <= RST_MASK;
    end else if (wr_go) begin
      unique case (wb_adr_i)
        REG_GT_BASE: begin
          gt_base_o <= BASE_W'(lane_merge({8'h00, gt_base_o}, wb_dat_i, wb_sel_i));
        end
        REG_GT_LIMIT: gt_lim_o <= LIM_W'(lane_merge({16'h0000, gt_lim_o}, wb_dat_i, wb_sel_i));
        REG_IO_LEVEL: begin
          io_level_o <= 2'(lane_merge({30'h0, io_level_o}, wb_dat_i, wb_sel_i));
        end
        REG_MASK: mask_q <= EVT_W'(lane_merge({28'h0, mask_q}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // New events win over the read that clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | evt_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (acc_go && !wb_we_i) begin
      unique case (wb_adr_i)
        REG_GT_BASE: wb_dat_o <= {8'h00, gt_base_o};
        REG_GT_LIMIT: wb_dat_o <= {16'h0000, gt_lim_o};
        REG_LT_SEL: wb_dat_o <= {16'h0000, lt_sel_i};
        REG_LT_BASE: wb_dat_o <= {8'h00, lt_base_i};
        REG_LT_LIMIT: wb_dat_o <= {16'h0000, lt_lim_i};
        REG_IO_LEVEL: wb_dat_o <= {30'h0, io_level_o};
        REG_STATUS: wb_dat_o <= {28'h0, status_q};
        REG_MASK: wb_dat_o <= {28'h0, mask_q};
        REG_FAULT: wb_dat_o <= fault_info_i;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule : spc_wb_regs

// File: dv/spc_top_monitor.sv
// Port checker for the segment protection checker.
// Assumes one clock and synchronous active-high reset; bound to spc_top.
`timescale 1ns/1ps
module spc_top_monitor (
  input logic clk_i,
  input logic rst_i,
  input logic wb_ack_o,
  input logic ld_req_i,
  input logic ld_busy_o,
  input logic ld_done_o,
  input logic ld_fault_o,
  input logic desc_rd_o,
  input logic [spc_pkg::BASE_W-1:0] desc_addr_o,
  input logic desc_ack_i,
  input logic ref_vld_i,
  input logic ref_go_o,
  input logic ref_fault_o,
  input logic io_req_i,
  input logic io_ok_o,
  input logic exc_o,
  input spc_pkg::spc_cause_t exc_cause_o,
  input logic [spc_pkg::SEL_W-1:0] exc_code_o
);
  import spc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ref_one_answer: assert property (ref_vld_i |-> ref_go_o ^ ref_fault_o)
    else $error("reference needs exactly one of go and fault");
  a_ref_fault_exc: assert property (ref_vld_i && ref_fault_o |=> exc_o
    && exc_cause_o inside {CAUSE_REF_LIMIT, CAUSE_REF_TYPE, CAUSE_REF_NULL})
    else $error("reference fault without reference-time exception");
  a_load_fault_exc: assert property (ld_fault_o |-> ld_done_o && exc_o
    && exc_cause_o inside {[CAUSE_LD_LIMIT:CAUSE_LD_NULL]})
    else $error("refused load without load-time exception");
  a_done_one_cycle: assert property (ld_done_o |=> !ld_done_o)
    else $error("load done longer than one cycle");
  a_busy_after_take: assert property (ld_req_i && !ld_busy_o |=> ld_busy_o)
    else $error("load request not taken");
  a_commit_then_done: assert property ($fell(ld_busy_o) |-> ld_done_o)
    else $error("load done missing after commit");
  a_desc_addr_hold: assert property (desc_rd_o && !desc_ack_i |=> $stable(desc_addr_o))
    else $error("descriptor address moved while waiting");
  a_io_fault_exc: assert property (io_req_i && !io_ok_o && !(ref_vld_i && ref_fault_o)
    |=> exc_o && exc_cause_o == CAUSE_IO_PRIV && exc_code_o == 16'h0000)
    else $error("refused io without io exception");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule : spc_top_monitor
bind spc_top spc_top_monitor mon_u (.clk_i, .rst_i, .wb_ack_o, .ld_req_i, .ld_busy_o,
  .ld_done_o, .ld_fault_o, .desc_rd_o, .desc_addr_o, .desc_ack_i, .ref_vld_i, .ref_go_o,
  .ref_fault_o, .io_req_i, .io_ok_o, .exc_o, .exc_cause_o, .exc_code_o);

// File: dv/spc_desc_mem.sv
// Descriptor fetch model of the processor side, answering dly_i+1 cycles after the read request.
// Assumes global table base zero, so address bits 6:3 index the table.
`timescale 1ns/1ps
module spc_desc_mem (
  input logic clk_i,
  input logic rst_i,
  input logic desc_rd_i,
  input logic [23:0] desc_addr_i,
  input logic [1:0] dly_i,
  output logic desc_ack_o,
  output logic [7:0] desc_acc_o,
  output logic [15:0] desc_lim_o,
  output logic [23:0] desc_base_o
);
  logic [7:0] acc_m [16];
  logic [1:0] cnt_q;
  initial begin
    desc_acc_o = 8'h00;
    desc_lim_o = 16'h0000;
    desc_base_o = 24'h000000;
    desc_ack_o = 1'b0;
  end
  // Released data lines show inverted values so stale data is never sampled
  always @(posedge clk_i) begin
    desc_ack_o <= 1'b0;
    desc_acc_o <= ~desc_acc_o;
    desc_lim_o <= ~desc_lim_o;
    desc_base_o <= ~desc_base_o;
    cnt_q <= 2'h0;
    if (desc_rd_i && !desc_ack_o && !rst_i) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == dly_i) begin
        desc_ack_o <= 1'b1;
        desc_acc_o <= acc_m[desc_addr_i[6:3]];
        desc_lim_o <= 16'h00FF;
        desc_base_o <= {4'h0, desc_addr_i[6:3], 16'h0000};
      end
    end
  end
endmodule : spc_desc_mem

// File: dv/spc_top_test.sv
// Self-checking bench for spc_top with a descriptor fetch model.
// Assumes the register map and cause codes of spc_pkg.
`timescale 1ns/1ps
module spc_top_test;
  import spc_pkg::*;
  typedef struct packed {spc_tgt_t tgt; logic [3:0] idx; logic [7:0] acc; spc_cause_t cause;} spc_row_t;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o, ld_req_i, ld_busy_o;
  logic ld_done_o, ld_fault_o, desc_rd_o, desc_ack_i, ref_vld_i, ref_wr_i, ref_exec_i;
  logic ref_go_o, ref_fault_o, io_req_i, io_ok_o, exc_o;
  logic [7:0] wb_adr_i, desc_acc_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  spc_tgt_t ld_tgt_i;
  logic [15:0] ld_sel_i, desc_lim_i, ref_off_i, exc_code_o;
  logic [23:0] desc_addr_o, desc_base_i, ref_base_o;
  logic [1:0] ref_seg_i, cpl_o, dly;
  spc_cause_t exc_cause_o;
  int n_errors = 0;
  int n_checks = 0;
  spc_row_t rows [14] = '{
    '{TGT_DS, 1, 8'h92, CAUSE_NONE}, '{TGT_SS, 2, 8'h90, CAUSE_LD_TYPE},
    '{TGT_ES, 3, 8'h00, CAUSE_LD_EMPTY}, '{TGT_DS, 4, 8'h12, CAUSE_LD_ABSENT},
    '{TGT_CS, 5, 8'h9A, CAUSE_NONE}, '{TGT_SS, 6, 8'h92, CAUSE_NONE},
    '{TGT_ES, 7, 8'h98, CAUSE_LD_TYPE}, '{TGT_CS, 0, 8'h00, CAUSE_LD_NULL},
    '{TGT_ES, 0, 8'h00, CAUSE_NONE}, '{TGT_LT, 1, 8'h92, CAUSE_LD_TYPE},
    '{TGT_DS, 12, 8'h92, CAUSE_LD_LIMIT}, '{TGT_CS, 8, 8'hFA, CAUSE_LD_PRIV},
    '{TGT_SS, 9, 8'hF2, CAUSE_LD_PRIV}, '{TGT_LT, 11, 8'h82, CAUSE_NONE}};
  spc_top dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_o, .ld_req_i, .ld_tgt_i, .ld_sel_i, .ld_busy_o,
    .ld_done_o, .ld_fault_o, .desc_rd_o, .desc_addr_o, .desc_ack_i, .desc_acc_i,
    .desc_lim_i, .desc_base_i, .ref_vld_i, .ref_seg_i, .ref_off_i, .ref_wr_i, .ref_exec_i,
    .ref_go_o, .ref_fault_o, .ref_base_o, .io_req_i, .io_ok_o, .cpl_o, .exc_o,
    .exc_cause_o, .exc_code_o);
  spc_desc_mem mem_u (.clk_i, .rst_i, .desc_rd_i(desc_rd_o), .desc_addr_i(desc_addr_o),
    .dly_i(dly), .desc_ack_o(desc_ack_i), .desc_acc_o(desc_acc_i), .desc_lim_o(desc_lim_i),
    .desc_base_o(desc_base_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task results;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int k;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    chk(wb_ack_o, 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task load(input spc_row_t r);
    int k;
    logic f;
    f = (r.cause != CAUSE_NONE);
    mem_u.acc_m[r.idx] = r.acc;
    ld_tgt_i <= r.tgt;
    ld_sel_i <= {9'h000, r.idx, 3'h0};
    ld_req_i <= 1'b1;
    @(posedge clk_i);
    ld_req_i <= 1'b0;
    @(posedge clk_i);
    chk(ld_busy_o, 1'b1);
    k = 0;
    while (ld_done_o !== 1'b1 && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    chk(ld_done_o, 1'b1);
    chk(ld_fault_o, f);
    chk(exc_o, f);
    if (f) chk({exc_code_o, 12'h000, exc_cause_o}, {9'h000, r.idx, 3'h0, 12'h000, r.cause});
  endtask : load
  task ref_chk(input logic [1:0] s, input logic [15:0] o, input logic w, input logic x,
               input spc_cause_t c);
    ref_seg_i <= s;
    ref_off_i <= o;
    ref_wr_i <= w;
    ref_exec_i <= x;
    ref_vld_i <= 1'b1;
    @(posedge clk_i);
    chk({ref_go_o, ref_fault_o}, {c == CAUSE_NONE, c != CAUSE_NONE});
    ref_vld_i <= 1'b0;
    @(posedge clk_i);
    chk(exc_o, c != CAUSE_NONE);
    if (c != CAUSE_NONE) chk(exc_cause_o, c);
  endtask : ref_chk
  initial begin
    rst_i = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, ld_req_i, ref_vld_i, ref_wr_i, ref_exec_i, io_req_i} = 8'h00;
    {wb_adr_i, wb_dat_i, wb_sel_i, ld_sel_i, ref_off_i, ref_seg_i, dly} = 80'h0;
    ld_tgt_i = TGT_ES;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(REG_GT_LIMIT, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0000FFFF);
    wb(REG_MASK, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    wb(REG_GT_LIMIT, 1'b1, 32'h0, 4'h2);
    wb(REG_GT_LIMIT, 1'b1, 32'h5F, 4'h1);
    wb(REG_GT_LIMIT, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0000005F);
    wb(REG_LT_SEL, 1'b1, 32'hFFFF, 4'hF);
    wb(REG_LT_SEL, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    wb(8'h40, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0);
    for (int i = 0; i < 14; i++) begin
      dly <= i[1:0];
      load(rows[i]);
    end
    wb(REG_LT_SEL, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h00000058);
    wb(REG_LT_BASE, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h000B0000);
    ref_chk(2'h3, 16'h00FF, 1'b0, 1'b0, CAUSE_NONE);
    chk(ref_base_o, 24'h010000);
    ref_chk(2'h3, 16'h0100, 1'b0, 1'b0, CAUSE_REF_LIMIT);
    ref_chk(2'h1, 16'h0010, 1'b1, 1'b0, CAUSE_REF_TYPE);
    ref_chk(2'h1, 16'h0010, 1'b0, 1'b1, CAUSE_NONE);
    ref_chk(2'h3, 16'h0010, 1'b0, 1'b1, CAUSE_REF_TYPE);
    ref_chk(2'h2, 16'h0010, 1'b1, 1'b0, CAUSE_NONE);
    ref_chk(2'h0, 16'h0000, 1'b0, 1'b0, CAUSE_REF_NULL);
    wb(REG_FAULT, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0000000A);
    chk(irq_o, 1'b0);
    wb(REG_MASK, 1'b1, 32'h2, 4'hF);
    chk(irq_o, 1'b1);
    wb(REG_STATUS, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0000000B);
    chk(irq_o, 1'b0);
    io_req_i <= 1'b1;
    @(posedge clk_i);
    chk(io_ok_o, 1'b1);
    io_req_i <= 1'b0;
    wb(REG_IO_LEVEL, 1'b1, 32'h3, 4'h1);
    wb(REG_IO_LEVEL, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h00000003);
    // Mid-run reset must drop the DS cache, clear the current level and restore the GT limit and I/O level registers
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(cpl_o, 2'h0);
    wb(REG_GT_LIMIT, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h0000FFFF);
    wb(REG_IO_LEVEL, 1'b0, 32'h0, 4'hF);
    chk(rd, 32'h00000000);
    ref_chk(2'h3, 16'h0000, 1'b0, 1'b0, CAUSE_REF_NULL);
    results;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    results;
  end
endmodule : spc_top_test
